// ---- cfs_serial_if.sv ----
// Purpose: Serial command-frame interface of a 48-channel PWM generator
// Assumes: Pins sampled by clk; serial and pwm clocks far slower than clk
// Notes:   Correction arithmetic and PWM comparators live elsewhere
// Notes on behaviour
// - PWM pins low except while self-test runs
// - Accept traffic after reset; data out low
// - Enable from disabled restarts PWM period
// - Frames 584 bits, channel 48 first, MSB first
// - Serial clock rise shifts data; last stage out
// - Latch captures command byte and executes it
// - Latch parallel-loads status frame for shifting
// - Status holds command nibble, flags, open-LED, corrections
// - Buffered serial clock copy drives out
// - Long latch high blanks outputs, resets all
// - No blank below maximum latch width
// - Every latch rise ends a frame
// - First clock after latch starts new frame
// - Sync error on clock-with-latch or misaligned latch
// - Sync error only reports, operation continues
// - Open-LED sampled per pwm clock, duplicated out except in self-test reports
// - Self-test walks channels, 64 pwm clocks each
// - Next status carries self-test results once
// - Only command upper nibble decoded
// - Latch high over 50 us resets chip
`timescale 1ns/1ns
module cfs_serial_if #(
   parameter int unsigned BLANK_CYCLES = cfs_pkg::CFS_BLANK_CYC
) (
   // System
   input  wire logic                                 clk,
   input  wire logic                                 rst_n,
   // Serial pins
   input  wire logic                                 latch_blank_pin,
   input  wire logic                                 serial_clock_in,
   input  wire logic                                 serial_data_in,
   output logic                                      serial_clock_out,
   output logic                                      serial_data_out,
   // PWM side pins
   input  wire logic                                 pwm_clock,
   input  wire logic                                 open_led_input,
   output logic [cfs_pkg::CFS_CHANNELS-1:0]          pwm_out,
   // PWM engine interface
   output logic                                      pwm_enable,
   output logic [cfs_pkg::CFS_PWM_BITS-1:0]          pwm_counter,
   output logic                                      pwm_period_start,
   output logic [cfs_pkg::CFS_DATA_BITS-1:0]         chan_data,
   output logic                                      update_sync_strobe,
   output logic                                      update_async_strobe,
   output logic [cfs_pkg::CFS_COR_ALL-1:0]           correction_values,
   // Status
   output logic                                      phase_shift_flag,
   output logic                                      correction_disable_flag,
   output logic                                      sync_error_flag,
   output logic                                      blank_active
);
   import cfs_pkg::*;

   logic [4:0]                pins_s;
   logic                      lb_s;
   logic                      sck_s;
   logic                      sdi_s;
   logic                      pck_s;
   logic                      ol_s;
   logic                      lb_d;
   logic                      sck_d;
   logic                      pck_d;
   logic [CFS_FRAME_BITS-1:0] frame_shift_register;
   logic [CFS_CNT_BITS-1:0]   bit_cnt;
   logic                      first_bit;
   logic                      cur_report;
   logic                      st_pending;
   logic [CFS_TMR_BITS-1:0]   high_tmr;
   logic                      ol_pwm;
   logic [CFS_CHANNELS-1:0]   st_res;
   logic [CFS_CH_IDX-1:0]     st_ch;
   logic [CFS_ST_BITS-1:0]    st_tick;
   cfs_st_t                   st_state;

   cfs_sync2 #(.WIDTH(5)) u_sync (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in ({latch_blank_pin, serial_clock_in, serial_data_in, pwm_clock,
                  open_led_input}),
      .sync_out (pins_s)
   );
   assign {lb_s, sck_s, sdi_s, pck_s, ol_s} = pins_s;

   // Edge detection on synchronised pins
   wire lat_rise = lb_s & ~lb_d;
   wire sck_rise = sck_s & ~sck_d;
   wire pck_rise = pck_s & ~pck_d;
   wire shift_en = sck_rise & ~lb_s;

   // Blank detection by a timer on clk, independent of the serial clock
   wire blank_hit = lb_s && (high_tmr >= CFS_TMR_BITS'(BLANK_CYCLES - 1));
   wire rst_all   = !rst_n || blank_hit;

   // Command decode: upper nibble only
   wire [3:0] cmd_byte_hi = frame_shift_register[7:4];
   wire       cmd_upd_s   = lat_rise && (cmd_byte_hi == CFS_CMD_UPD_SYNC);
   wire       cmd_upd_a   = lat_rise && (cmd_byte_hi == CFS_CMD_UPD_ASYNC);
   wire       cmd_corr    = lat_rise && (cmd_byte_hi == CFS_CMD_CORR);
   wire       cmd_en      = lat_rise && (cmd_byte_hi == CFS_CMD_OUT_EN);
   wire       cmd_dis     = lat_rise && (cmd_byte_hi == CFS_CMD_OUT_DIS);
   wire       cmd_st      = lat_rise && (cmd_byte_hi == CFS_CMD_SELFTEST);
   wire       cmd_phs     = lat_rise && (cmd_byte_hi == CFS_CMD_PHASE);
   wire       cmd_crd     = lat_rise && (cmd_byte_hi == CFS_CMD_CORR_TGL);

   // Sync error causes
   wire err_clk   = sck_rise & lb_s;
   wire err_align = lat_rise & (bit_cnt != '0);
   wire err_now   = err_clk | err_align;

   // Status frame image and open-LED duplication mask
   logic [CFS_FRAME_BITS-1:0] status_img;
   logic [CFS_FRAME_BITS-1:0] ol_mask;
   logic [CFS_FRAME_BITS-1:0] next_cor_src;

   genvar n;
   generate
      for (n = 0; n < CFS_CHANNELS; n++) begin : g_ch
         localparam int unsigned BASE = CFS_CMD_BITS + n * CFS_FIELD_BITS;
         assign status_img[BASE + CFS_FIELD_BITS - 1 : BASE] =
            {correction_values[n*CFS_COR_BITS +: CFS_COR_BITS], 5'h00,
             st_pending & st_res[n]};
         assign ol_mask[BASE + CFS_FIELD_BITS - 1 : BASE] = 12'h001;
         assign next_cor_src[BASE + CFS_FIELD_BITS - 1 : BASE] =
            frame_shift_register[BASE + CFS_FIELD_BITS - 1 : BASE];
      end
   endgenerate
   assign status_img[CFS_CMD_BITS-1:0] = {cmd_byte_hi, st_pending,
                                          sync_error_flag | err_now,
                                          phase_shift_flag,
                                          correction_disable_flag};
   assign ol_mask[CFS_CMD_BITS-1:0]      = 8'h00;
   assign next_cor_src[CFS_CMD_BITS-1:0] = 8'h00;

   // First shift of a frame other than a self-test report copies the open-LED sample into bit 0 of every channel field
   wire dup_ol = first_bit && !cur_report;
   wire [CFS_FRAME_BITS-1:0] shift_src =
      dup_ol ? ((frame_shift_register & ~ol_mask) | (ol_pwm ? ol_mask : '0))
             : frame_shift_register;

   // Edge history and buffered clock out
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         lb_d             <= 1'b0;
         sck_d            <= 1'b0;
         pck_d            <= 1'b0;
         serial_clock_out <= 1'b0;
      end else begin
         lb_d             <= lb_s;
         sck_d            <= sck_s;
         pck_d            <= pck_s;
         serial_clock_out <= sck_s;
      end
   end

   // Latch high-time timer, cleared whenever the pin is low
   always_ff @(posedge clk) begin
      if (!rst_n || !lb_s) begin
         high_tmr <= '0;
      end else if (!blank_hit) begin
         high_tmr <= high_tmr + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         blank_active <= 1'b0;
      end else begin
         blank_active <= blank_hit;
      end
   end

   // Frame shift register
   always_ff @(posedge clk) begin
      if (rst_all) begin
         frame_shift_register <= '0;
      end else if (lat_rise) begin
         frame_shift_register <= status_img;
      end else if (shift_en) begin
         frame_shift_register <= {shift_src[CFS_FRAME_BITS-2:0], sdi_s};
      end
   end
   assign serial_data_out = frame_shift_register[CFS_FRAME_BITS-1];

   // Frame bit counter and first-bit marker
   always_ff @(posedge clk) begin
      if (rst_all) begin
         bit_cnt    <= '0;
         first_bit  <= 1'b1;
         cur_report <= 1'b0;
      end else if (lat_rise) begin
         bit_cnt    <= '0;
         first_bit  <= 1'b1;
         cur_report <= st_pending;
      end else if (shift_en) begin
         bit_cnt    <= (bit_cnt == CFS_LAST_BIT) ? '0 : bit_cnt + 1'b1;
         first_bit  <= 1'b0;
      end
   end

   // Sync error flag: set wins over the clear at status load
   always_ff @(posedge clk) begin
      if (rst_all) begin
         sync_error_flag <= 1'b0;
      end else if (err_now) begin
         sync_error_flag <= 1'b1;
      end else if (lat_rise) begin
         sync_error_flag <= 1'b0;
      end
   end

   // Command execution
   always_ff @(posedge clk) begin
      if (rst_all) begin
         chan_data               <= '0;
         update_sync_strobe      <= 1'b0;
         update_async_strobe     <= 1'b0;
         phase_shift_flag        <= 1'b0;
         correction_disable_flag <= 1'b0;
         st_pending              <= 1'b0;
      end else begin
         update_sync_strobe  <= cmd_upd_s;
         update_async_strobe <= cmd_upd_a;
         if (cmd_upd_s || cmd_upd_a) begin
            chan_data <= frame_shift_register[CFS_FRAME_BITS-1:CFS_CMD_BITS];
         end
         if (cmd_phs) begin
            phase_shift_flag <= ~phase_shift_flag;
         end
         if (cmd_crd) begin
            correction_disable_flag <= ~correction_disable_flag;
         end
         if (lat_rise) begin
            st_pending <= cmd_st;
         end
      end
   end

   // Correction values: low six bits of each channel field
   generate
      for (n = 0; n < CFS_CHANNELS; n++) begin : g_cor
         localparam int unsigned BASE = CFS_CMD_BITS + n * CFS_FIELD_BITS;
         always_ff @(posedge clk) begin
            if (rst_all) begin
               correction_values[n*CFS_COR_BITS +: CFS_COR_BITS] <= '0;
            end else if (cmd_corr) begin
               correction_values[n*CFS_COR_BITS +: CFS_COR_BITS] <=
                  next_cor_src[BASE +: CFS_COR_BITS];
            end
         end
      end
   endgenerate

   // Output enable and pwm period counter
   always_ff @(posedge clk) begin
      if (rst_all) begin
         pwm_enable       <= 1'b0;
         pwm_counter      <= '0;
         pwm_period_start <= 1'b0;
      end else begin
         pwm_period_start <= pwm_enable && !cmd_dis && pck_rise && (pwm_counter == '0);
         if (cmd_en && !pwm_enable) begin
            pwm_enable  <= 1'b1;
            pwm_counter <= '0;
         end else if (cmd_dis) begin
            pwm_enable  <= 1'b0;
            pwm_counter <= '0;
         end else if (pwm_enable && pck_rise) begin
            pwm_counter <= pwm_counter + 1'b1;
         end
      end
   end

   // Open-LED sample on every pwm clock rise
   always_ff @(posedge clk) begin
      if (rst_all) begin
         ol_pwm <= 1'b1;
      end else if (pck_rise) begin
         ol_pwm <= ol_s;
      end
   end

   // Self-test walk over channels
   wire st_step = (st_state == CFS_ST_RUN) && pck_rise;
   wire st_last = st_tick == CFS_ST_LAST_TICK;

   always_ff @(posedge clk) begin
      if (rst_all) begin
         st_state <= CFS_ST_IDLE;
         st_ch    <= '0;
         st_tick  <= '0;
      end else begin
         unique case (st_state)
            CFS_ST_IDLE: begin
               if (cmd_st) begin
                  st_state <= CFS_ST_RUN;
                  st_ch    <= '0;
                  st_tick  <= '0;
               end
            end
            CFS_ST_RUN: begin
               if (st_step) begin
                  st_tick <= st_tick + 1'b1;
                  if (st_last) begin
                     st_ch <= st_ch + 1'b1;
                     if (st_ch == CFS_ST_LAST_CH) begin
                        st_state <= CFS_ST_IDLE;
                     end
                  end
               end
            end
         endcase
      end
   end

   // Result capture at the last tick of each channel dwell
   generate
      for (n = 0; n < CFS_CHANNELS; n++) begin : g_res
         always_ff @(posedge clk) begin
            if (rst_all || cmd_st) begin
               st_res[n] <= 1'b0;
            end else if (st_step && st_last && (st_ch == CFS_CH_IDX'(n))) begin
               st_res[n] <= ol_s;
            end
         end
      end
   endgenerate

   // PWM pins: only the self-test drives them here
   always_ff @(posedge clk) begin
      if (rst_all || st_state == CFS_ST_IDLE) begin
         pwm_out <= '0;
      end else begin
         pwm_out <= CFS_CHANNELS'(1) << st_ch;
      end
   end
endmodule // cfs_serial_if

// ---- cfs_pkg.sv ----
// Purpose: Shared constants for the cascadable frame serial interface
// Assumes: 100 MHz system clock
// Notes:   Frame layout is channel 48 first, command byte in the low 8 bits
package cfs_pkg;
   localparam int unsigned CFS_CHANNELS   = 48;
   localparam int unsigned CFS_FIELD_BITS = 12;
   localparam int unsigned CFS_CMD_BITS   = 8;
   localparam int unsigned CFS_FRAME_BITS = CFS_CHANNELS * CFS_FIELD_BITS + CFS_CMD_BITS;
   localparam int unsigned CFS_DATA_BITS  = CFS_CHANNELS * CFS_FIELD_BITS;
   localparam int unsigned CFS_COR_BITS   = 6;
   localparam int unsigned CFS_COR_ALL    = CFS_CHANNELS * CFS_COR_BITS;
   localparam int unsigned CFS_CNT_BITS   = 10;
   localparam int unsigned CFS_PWM_BITS   = 12;
   localparam int unsigned CFS_CH_IDX     = 6;
   localparam int unsigned CFS_ST_BITS    = 6;

   // Field positions inside one channel field of the status frame
   localparam int unsigned CFS_STAT_OL_POS  = 0;
   localparam int unsigned CFS_STAT_COR_POS = 6;
   // Field positions inside the status command slot
   localparam int unsigned CFS_STAT_CRD_POS = 0;
   localparam int unsigned CFS_STAT_PHS_POS = 1;
   localparam int unsigned CFS_STAT_SYC_POS = 2;
   localparam int unsigned CFS_STAT_OLT_POS = 3;
   localparam int unsigned CFS_STAT_CMD_POS = 4;

   // Command codes, upper nibble of the command byte
   localparam logic [3:0] CFS_CMD_UPD_SYNC  = 4'h0;
   localparam logic [3:0] CFS_CMD_UPD_ASYNC = 4'h1;
   localparam logic [3:0] CFS_CMD_CORR      = 4'h2;
   localparam logic [3:0] CFS_CMD_OUT_EN    = 4'h3;
   localparam logic [3:0] CFS_CMD_OUT_DIS   = 4'h4;
   localparam logic [3:0] CFS_CMD_SELFTEST  = 4'h5;
   localparam logic [3:0] CFS_CMD_PHASE     = 4'h6;
   localparam logic [3:0] CFS_CMD_CORR_TGL  = 4'h7;

   // Last self-test tick of each channel dwell in pwm clocks, last self-test channel, last frame bit
   localparam logic [CFS_ST_BITS-1:0] CFS_ST_LAST_TICK = 6'h3f;
   localparam logic [CFS_CH_IDX-1:0]  CFS_ST_LAST_CH   = 6'h2f;
   localparam logic [CFS_CNT_BITS-1:0] CFS_LAST_BIT    = 10'h247;

   // Timing
   localparam int unsigned CFS_CLK_NS        = 10;
   localparam int unsigned CFS_LATCH_MAX_NS  = 5000;
   localparam int unsigned CFS_BLANK_MIN_NS  = 50000;
   localparam int unsigned CFS_LATCH_MAX_CYC = CFS_LATCH_MAX_NS / CFS_CLK_NS;
   localparam int unsigned CFS_BLANK_CYC     = (CFS_BLANK_MIN_NS + CFS_CLK_NS - 1) / CFS_CLK_NS;
   localparam int unsigned CFS_TMR_BITS      = 16;

   typedef enum logic {CFS_ST_IDLE, CFS_ST_RUN} cfs_st_t;
endpackage

// ---- cfs_sync2.sv ----
// Purpose: Two-flop synchroniser for a group of level inputs
// Assumes: Inputs come from outside the clk domain
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ns
module cfs_sync2 #(
   parameter int unsigned WIDTH = 1
) (
   // System
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stage1   <= '0;
         sync_out <= '0;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule // cfs_sync2

// ---- cfs_serial_if_monitor.sv ----
// Purpose: Concurrent checks on the serial frame interface ports
// Assumes: Pins are sampled by clk
// Notes:   Bound into every cfs_serial_if instance
`timescale 1ns/1ns
module cfs_serial_if_monitor
   import cfs_pkg::*;
#(
   parameter int unsigned BLANK_CYCLES = CFS_BLANK_CYC
) (
   // System
   input wire logic                             clk,
   input wire logic                             rst_n,
   // Serial pins
   input wire logic                             latch_blank_pin,
   input wire logic                             serial_clock_in,
   input wire logic                             serial_clock_out,
   input wire logic                             serial_data_out,
   // PWM side
   input wire logic [cfs_pkg::CFS_CHANNELS-1:0] pwm_out,
   input wire logic                             pwm_enable,
   input wire logic [cfs_pkg::CFS_PWM_BITS-1:0] pwm_counter,
   input wire logic                             pwm_period_start,
   input wire logic                             update_sync_strobe,
   input wire logic                             update_async_strobe,
   // Status
   input wire logic                             sync_error_flag,
   input wire logic                             blank_active
);
   logic [15:0] hi_cnt;

   // Raw high time of the latch pin
   always_ff @(posedge clk) begin
      if (!rst_n || !latch_blank_pin) hi_cnt <= 16'h0;
      else if (hi_cnt != 16'hffff) hi_cnt <= hi_cnt + 16'h1;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_latch_clk;
      latch_blank_pin [*4] ##1 (latch_blank_pin && $rose(serial_clock_in)) ##1 latch_blank_pin [*4];
   endsequence
   sequence s_one_shot;
      latch_blank_pin ##1 (!update_sync_strobe && !update_async_strobe);
   endsequence

   chk_reset_quiet: assert property (!$past(rst_n) |-> !serial_data_out && !pwm_enable && pwm_out == '0)
      else $error("outputs active after reset");
   chk_clk_buffer: assert property ($rose(serial_clock_in) |-> ##[2:4] $rose(serial_clock_out))
      else $error("serial clock not passed through");
   chk_pwm_onehot: assert property ($onehot0(pwm_out))
      else $error("more than one pwm pin high");
   chk_blank_off: assert property (blank_active |-> !pwm_enable && pwm_out == '0 && !serial_data_out)
      else $error("outputs alive during blank");
   chk_no_early_blank: assert property (hi_cnt != 16'h0 && hi_cnt < BLANK_CYCLES |-> !blank_active)
      else $error("blank on a short latch");
   chk_blank_onset: assert property (hi_cnt == BLANK_CYCLES + 6 |-> blank_active)
      else $error("blank missing on long latch");
   chk_strobe_once: assert property ((update_sync_strobe || update_async_strobe) |-> s_one_shot)
      else $error("update strobe outside latch or too long");
   chk_sync_clk: assert property (s_latch_clk |-> ##[0:4] sync_error_flag)
      else $error("clock during latch not flagged");
   chk_counter_idle: assert property (!pwm_enable && !$past(pwm_enable) |-> pwm_counter == '0)
      else $error("pwm counter runs while disabled");
   chk_period_start: assert property (pwm_period_start |-> pwm_enable ##1 !pwm_period_start)
      else $error("period start while disabled");
endmodule // cfs_serial_if_monitor

bind cfs_serial_if cfs_serial_if_monitor #(.BLANK_CYCLES(BLANK_CYCLES)) i_cfs_serial_if_monitor (
   .clk(clk), .rst_n(rst_n), .latch_blank_pin(latch_blank_pin),
   .serial_clock_in(serial_clock_in), .serial_clock_out(serial_clock_out),
   .serial_data_out(serial_data_out), .pwm_out(pwm_out), .pwm_enable(pwm_enable),
   .pwm_counter(pwm_counter), .pwm_period_start(pwm_period_start),
   .update_sync_strobe(update_sync_strobe), .update_async_strobe(update_async_strobe),
   .sync_error_flag(sync_error_flag), .blank_active(blank_active));

// ---- cfs_host_model.sv ----
// Purpose: Host controller driving frames into the serial interface
// Assumes: Pins change on the falling clk edge, 80 ns serial clock
// Notes:   Returned data is taken just before each serial clock rise
`timescale 1ns/1ns
module cfs_host_model (
   // System
   input  wire logic clk,
   // Pins toward the device
   output logic      latch_blank_pin,
   output logic      serial_clock_in,
   output logic      serial_data_in,
   // Returned data
   input  wire logic serial_data_out
);
   logic [583:0] rx;

   initial begin
      latch_blank_pin = 1'b0;
      serial_clock_in = 1'b0;
      serial_data_in  = 1'b0;
      rx              = '0;
   end

   task automatic wait_n(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Channel 48 first, MSB first; clock stands low outside frames
   task automatic send(input logic [583:0] f, input int n);
      for (int i = 0; i < n; i++) begin
         serial_data_in = f[583-i];
         wait_n(4);
         rx = {rx[582:0], serial_data_out};
         serial_clock_in = 1'b1;
         wait_n(4);
         serial_clock_in = 1'b0;
      end
      serial_data_in = ~serial_data_in;
   endtask

   // Pin high for 8 + hold clocks; ck pulses the serial clock inside
   task automatic latch(input int hold, input logic ck);
      wait_n(4);
      latch_blank_pin = 1'b1;
      wait_n(4);
      serial_clock_in = ck;
      wait_n(4);
      serial_clock_in = 1'b0;
      wait_n(hold);
      latch_blank_pin = 1'b0;
      wait_n(8);
   endtask
endmodule // cfs_host_model

// ---- cfs_serial_if_tb.sv ----
// Purpose: Self-checking bench for the serial frame interface
// Assumes: 100 MHz clk, 80 ns serial clock, 60 ns pwm clock
// Notes:   Blank time shortened through BLANK_CYCLES
`timescale 1ns/1ns
module cfs_serial_if_tb;
   import cfs_pkg::*;
   localparam int unsigned BLANK = 50;
   logic                     clk = 1'b0;
   logic                     rst_n = 1'b0;
   logic                     pwm_clock = 1'b0;
   logic                     open_led_input = 1'b1;
   logic                     latch_blank_pin, serial_clock_in, serial_data_in;
   logic                     serial_clock_out, serial_data_out;
   logic [CFS_CHANNELS-1:0]  pwm_out;
   logic                     pwm_enable, pwm_period_start;
   logic [CFS_PWM_BITS-1:0]  pwm_counter;
   logic [CFS_DATA_BITS-1:0] chan_data;
   logic                     update_sync_strobe, update_async_strobe;
   logic [CFS_COR_ALL-1:0]   correction_values;
   logic                     phase_shift_flag, correction_disable_flag;
   logic                     sync_error_flag, blank_active;
   int error_cnt = 0, check_count = 0, cyc = 0, pdiv = 0;
   int starts = 0, walk = 0, dwell = 0, blanks = 0, ustr = 0;

   cfs_serial_if #(.BLANK_CYCLES(BLANK)) i_cfs_serial_if (
      .clk(clk), .rst_n(rst_n), .latch_blank_pin(latch_blank_pin),
      .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
      .serial_clock_out(serial_clock_out), .serial_data_out(serial_data_out),
      .pwm_clock(pwm_clock), .open_led_input(open_led_input), .pwm_out(pwm_out),
      .pwm_enable(pwm_enable), .pwm_counter(pwm_counter), .pwm_period_start(pwm_period_start),
      .chan_data(chan_data), .update_sync_strobe(update_sync_strobe),
      .update_async_strobe(update_async_strobe), .correction_values(correction_values),
      .phase_shift_flag(phase_shift_flag), .correction_disable_flag(correction_disable_flag),
      .sync_error_flag(sync_error_flag), .blank_active(blank_active));

   cfs_host_model i_cfs_host_model (
      .clk(clk), .latch_blank_pin(latch_blank_pin), .serial_clock_in(serial_clock_in),
      .serial_data_in(serial_data_in), .serial_data_out(serial_data_out));

   always #5 clk = ~clk;

   // PWM clock runs free from the start, before any enable
   always @(negedge clk) begin
      pdiv <= (pdiv == 2) ? 0 : pdiv + 1;
      if (pdiv == 2) pwm_clock <= ~pwm_clock;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (pwm_period_start === 1'b1) starts <= starts + 1;
      // Channel 2 dwell starts on a pwm clock edge, so its length is exact
      if (pwm_out[1] === 1'b1) dwell <= dwell + 1;
      if (update_async_strobe === 1'b1) ustr <= ustr + 1;
      if (blank_active === 1'b1) blanks <= blanks + 1;
      if (walk < 48 && pwm_out[walk] === 1'b1) walk <= walk + 1;
      if (cyc == 100000) begin
         error_cnt++;
         conclude();
      end
   end

   task automatic chk_bit(input string n, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %b seen %b", n, e, g);
      end
   endtask

   task automatic chk_vec(input string n, input logic [583:0] e, input logic [583:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   function automatic logic [583:0] mk(input logic [7:0] cmd, input logic [3:0] hi);
      logic [583:0] f;
      f = {576'h0, cmd};
      for (int n = 0; n < 48; n++) f[8+12*n +: 12] = {hi, 8'(n * 5 + 1)};
      return f;
   endfunction

   // Status shows the correction values held before the latch that loads it
   function automatic logic [583:0] st(input logic [7:0] slot, input logic ol,
                                      input logic cor);
      logic [583:0] s;
      s = {576'h0, slot};
      for (int n = 0; n < 48; n++) s[8+12*n +: 12] = {cor ? 6'(n * 5 + 1) : 6'h0, 5'h0, ol};
      return s;
   endfunction

   function automatic logic [583:0] corv();
      logic [583:0] c;
      c = '0;
      for (int n = 0; n < 48; n++) c[6*n +: 6] = 6'(n * 5 + 1);
      return c;
   endfunction

   task automatic frame(input logic [583:0] f);
      i_cfs_host_model.send(f, 584);
      i_cfs_host_model.latch(2, 1'b0);
   endtask

   task automatic t_startup;
      chk_bit("pwm_enable", 1'b0, pwm_enable);
      chk_vec("pwm_out", 584'h0, {536'h0, pwm_out});
      chk_bit("serial_data_out", 1'b0, serial_data_out);
      frame(mk(8'h2a, 4'h1));
      chk_vec("correction_values", corv(), {296'h0, correction_values});
      frame(mk(8'h15, 4'h7));
      chk_vec("status", st(8'h20, 1'b1, 1'b0), i_cfs_host_model.rx);
      chk_vec("chan_data", mk(8'h15, 4'h7) >> 8, {8'h0, chan_data});
      chk_vec("async_strobes", 584'h1, 584'(ustr));
      frame(mk(8'h30, 4'h2));
      repeat (20) @(negedge clk);
      chk_vec("status", st(8'h10, 1'b1, 1'b1), i_cfs_host_model.rx);
      chk_bit("pwm_enable", 1'b1, pwm_enable);
      chk_vec("period_starts", 584'h1, 584'(starts));
      $display("test startup done");
   endtask

   task automatic t_sync;
      i_cfs_host_model.send(584'h0, 100);
      i_cfs_host_model.latch(2, 1'b0);
      chk_bit("sync_error_flag", 1'b1, sync_error_flag);
      frame(mk(8'h6f, 4'h3));
      chk_vec("status_slot", 584'h04, {576'h0, i_cfs_host_model.rx[7:0]});
      chk_bit("sync_error_flag", 1'b0, sync_error_flag);
      chk_bit("phase_shift_flag", 1'b1, phase_shift_flag);
      i_cfs_host_model.send(mk(8'h70, 4'h4), 584);
      i_cfs_host_model.latch(2, 1'b1);
      // Flags show their state before the latch; the error flag is still set
      chk_vec("status", st(8'h64, 1'b1, 1'b1), i_cfs_host_model.rx);
      chk_bit("sync_error_flag", 1'b1, sync_error_flag);
      chk_bit("correction_disable_flag", 1'b1, correction_disable_flag);
      $display("test sync done");
   endtask

   task automatic t_selftest;
      int n;
      open_led_input = 1'b0;
      frame(mk(8'h5c, 4'h5));
      for (n = 0; n < 25000 && (walk < 48 || pwm_out !== '0); n++) @(negedge clk);
      chk_vec("channels_walked", 584'd48, 584'(walk));
      chk_vec("channel_dwell", 584'd384, 584'(dwell));
      frame(mk(8'h00, 4'h6));
      open_led_input = 1'b1;
      frame(mk(8'h01, 4'h6));
      chk_vec("status", st(8'h0b, 1'b0, 1'b1), i_cfs_host_model.rx);
      frame(mk(8'h4f, 4'h6));
      chk_vec("status", st(8'h03, 1'b1, 1'b1), i_cfs_host_model.rx);
      chk_bit("pwm_enable", 1'b0, pwm_enable);
      $display("test selftest done");
   endtask

   task automatic t_blank;
      i_cfs_host_model.latch(80, 1'b0);
      chk_bit("blank_seen", 1'b1, blanks != 0);
      chk_bit("phase_shift_flag", 1'b0, phase_shift_flag);
      chk_bit("correction_disable_flag", 1'b0, correction_disable_flag);
      chk_bit("serial_data_out", 1'b0, serial_data_out);
      chk_vec("correction_values", 584'h0, {296'h0, correction_values});
      $display("test blank done");
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      t_startup();
      t_sync();
      t_selftest();
      t_blank();
      conclude();
   end
endmodule // cfs_serial_if_tb
